// [nsx_defines.svh]
// Constants for the nibble strobe expander host controller.
// Assumes a 100 MHz sys_clk; times are in ns.
`ifndef NSX_DEFINES_SVH
`define NSX_DEFINES_SVH
`define NSX_OP_READ 2'h0
`define NSX_OP_WRITE 2'h1
`define NSX_OP_OR 2'h2
`define NSX_OP_AND 2'h3
`define NSX_CLK_NS 10
`define NSX_CMD_SETUP_NS 100
`define NSX_CMD_HOLD_NS 60
`define NSX_DATA_SETUP_NS 200
`define NSX_DATA_HOLD_NS 20
`define NSX_STROBE_LOW_NS 700
`define NSX_ACCESS_NS 650
`define NSX_CS_SETUP_NS 50
`define NSX_CS_HOLD_NS 50
`define NSX_CYC(ns) ((ns + `NSX_CLK_NS - 1) / `NSX_CLK_NS)
`define NSX_CMD_SETUP_CYC `NSX_CYC(`NSX_CMD_SETUP_NS)
`define NSX_CMD_HOLD_CYC `NSX_CYC(`NSX_CMD_HOLD_NS)
`define NSX_DATA_SETUP_CYC `NSX_CYC(`NSX_DATA_SETUP_NS)
`define NSX_DATA_HOLD_CYC `NSX_CYC(`NSX_DATA_HOLD_NS)
`define NSX_STROBE_LOW_CYC `NSX_CYC(`NSX_STROBE_LOW_NS)
`define NSX_ACCESS_CYC (`NSX_CYC(`NSX_ACCESS_NS) + 1)
`define NSX_CS_SETUP_CYC `NSX_CYC(`NSX_CS_SETUP_NS)
`define NSX_CS_HOLD_CYC `NSX_CYC(`NSX_CS_HOLD_NS)
`endif

// [nsx_pkg.sv]
// Types for the nibble strobe expander host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package nsx_pkg;
    typedef enum logic [2:0] {
        NSX_IDLE, NSX_CS, NSX_CMD, NSX_LOW, NSX_HOLD, NSX_CSH
    } nsx_state_t;

    typedef struct packed {
        logic [1:0] op;
        logic [1:0] port;
        logic [3:0] data;
    } nsx_req_t;

    typedef struct packed {
        nsx_state_t state;
        logic [7:0] count;
        nsx_req_t req;
        logic strobe;
        logic cs_n;
        logic bus_out;
        logic bus_oe;
        logic [3:0] rdata;
        logic done;
        logic [3:0] port_out;
        logic dummy;
    } nsx_regs_t;
endpackage

// [nsx_host.sv]
// Host controller that drives a nibble strobe expander over its pins.
// Assumes one 100 MHz clock and one expander on the strobe and select.
`timescale 1ns/10ps
`default_nettype none
`include "nsx_defines.svh"
module nsx_host (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire nsx_pkg::nsx_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic [3:0] rdata,
    output logic done,
    output logic strobe,
    output logic chip_select_n,
    input wire logic [3:0] host_nibble_bus_in,
    output logic [3:0] host_nibble_bus_out,
    output logic host_nibble_bus_oe
);
    logic rst_a;
    logic rst_b;
    logic [3:0] bus_s1;
    logic [3:0] bus_s2;
    logic [3:0] bus_s3;
    logic [3:0] bus_f;
    nsx_pkg::nsx_regs_t r;
    nsx_pkg::nsx_regs_t next_r;

    function automatic logic [7:0] cyc8(input int n);
        cyc8 = 8'(n - 1);
    endfunction

    // Read of a port last written: it may still drive its latch
    function automatic logic needs_dummy(input nsx_pkg::nsx_req_t q,
        input logic [3:0] outs);
        needs_dummy = (q.op == `NSX_OP_READ) && outs[q.port];
    endfunction

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_a <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_b <= rst_a;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_s1 <= 4'h0;
            bus_s2 <= 4'h0;
            bus_s3 <= 4'h0;
            bus_f <= 4'h0;
        end else begin
            bus_s1 <= host_nibble_bus_in;
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
            // Take a new level only once two stages agree
            bus_f <= (bus_s2 == bus_s3) ? bus_s3 : bus_f;
        end
    end

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        unique case (r.state)
            nsx_pkg::NSX_IDLE: begin
                if (req_valid) begin
                    next_r.req = req;
                    // Former output port gets a throwaway read first
                    next_r.dummy = needs_dummy(req, r.port_out);
                    next_r.port_out[req.port] = (req.op != `NSX_OP_READ);
                    next_r.cs_n = 1'b0;
                    // Command nibble: op in upper bits, port in lower
                    next_r.bus_out = 1'b1;
                    next_r.bus_oe = 1'b1;
                    next_r.count = cyc8(`NSX_CS_SETUP_CYC
                        + `NSX_CMD_SETUP_CYC);
                    next_r.state = nsx_pkg::NSX_CMD;
                end
            end
            nsx_pkg::NSX_CMD: begin
                if (r.count == 8'h00) begin
                    // Falling edge captures the command
                    next_r.strobe = 1'b0;
                    next_r.count = cyc8(`NSX_CMD_HOLD_CYC);
                    next_r.state = nsx_pkg::NSX_CS;
                end else begin
                    next_r.count = r.count - 8'h01;
                end
            end
            nsx_pkg::NSX_CS: begin
                if (r.count == 8'h00) begin
                    // Read releases the bus, writes present data
                    next_r.bus_out = 1'b0;
                    next_r.bus_oe = (r.req.op != `NSX_OP_READ);
                    next_r.count = cyc8(`NSX_STROBE_LOW_CYC
                        - `NSX_CMD_HOLD_CYC);
                    next_r.state = nsx_pkg::NSX_LOW;
                end else begin
                    next_r.count = r.count - 8'h01;
                end
            end
            nsx_pkg::NSX_LOW: begin
                if (r.count == 8'h00) begin
                    // Sample while strobe still low, then raise it
                    if (!r.dummy) begin
                        next_r.rdata = bus_f;
                    end
                    next_r.strobe = 1'b1;
                    next_r.count = cyc8(`NSX_DATA_HOLD_CYC
                        + `NSX_CS_HOLD_CYC);
                    next_r.state = nsx_pkg::NSX_HOLD;
                end else begin
                    next_r.count = r.count - 8'h01;
                end
            end
            nsx_pkg::NSX_HOLD: begin
                if (r.count == 8'h00) begin
                    next_r.bus_oe = 1'b0;
                    // Deselect freezes the device between transfers
                    next_r.cs_n = 1'b1;
                    next_r.state = nsx_pkg::NSX_CSH;
                end else begin
                    next_r.count = r.count - 8'h01;
                end
            end
            nsx_pkg::NSX_CSH: begin
                if (r.dummy) begin
                    // Repeat the read now that the port has let go
                    next_r.dummy = 1'b0;
                    next_r.cs_n = 1'b0;
                    next_r.bus_out = 1'b1;
                    next_r.bus_oe = 1'b1;
                    next_r.count = cyc8(`NSX_CS_SETUP_CYC
                        + `NSX_CMD_SETUP_CYC);
                    next_r.state = nsx_pkg::NSX_CMD;
                end else begin
                    next_r.done = 1'b1;
                    next_r.state = nsx_pkg::NSX_IDLE;
                end
            end
            default: next_r.state = nsx_pkg::NSX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{state: nsx_pkg::NSX_IDLE, count: 8'h00,
                req: '0, strobe: 1'b1, cs_n: 1'b1, bus_out: 1'b0,
                bus_oe: 1'b0, rdata: 4'h0, done: 1'b0, port_out: 4'h0,
                dummy: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign req_ready = (r.state == nsx_pkg::NSX_IDLE);
    assign rdata = r.rdata;
    assign done = r.done;
    assign strobe = r.strobe;
    assign chip_select_n = r.cs_n;
    assign host_nibble_bus_oe = r.bus_oe;
    // Command nibble then data nibble
    assign host_nibble_bus_out = r.bus_out ? {r.req.op, r.req.port}
        : r.req.data;

    property p_fall_has_cmd;
        @(posedge sys_clk) disable iff (!rst_b)
        $fell(strobe) |-> host_nibble_bus_oe && !chip_select_n
            && host_nibble_bus_out == {r.req.op, r.req.port};
    endproperty
    a_fall_has_cmd: assert property (p_fall_has_cmd)
        else $error("strobe fell without command on bus");

    property p_read_released;
        @(posedge sys_clk) disable iff (!rst_b)
        (r.state == nsx_pkg::NSX_LOW && r.req.op == `NSX_OP_READ)
            |-> !host_nibble_bus_oe && !strobe;
    endproperty
    a_read_released: assert property (p_read_released)
        else $error("host drives bus during read");

    property p_write_data;
        @(posedge sys_clk) disable iff (!rst_b)
        ($rose(strobe) && r.req.op != `NSX_OP_READ)
            |-> host_nibble_bus_oe && host_nibble_bus_out == r.req.data;
    endproperty
    a_write_data: assert property (p_write_data)
        else $error("write data missing at strobe rise");

    property p_low_width;
        @(posedge sys_clk) disable iff (!rst_b)
        $fell(strobe) |-> !strobe [*8];
    endproperty
    a_low_width: assert property (p_low_width)
        else $error("strobe low too short");

    property p_cs_freeze;
        @(posedge sys_clk) disable iff (!rst_b)
        chip_select_n |-> strobe;
    endproperty
    a_cs_freeze: assert property (p_cs_freeze)
        else $error("strobe low while deselected");

    property p_done_bound;
        @(posedge sys_clk) disable iff (!rst_b)
        (req_valid && req_ready && !needs_dummy(req, r.port_out))
            |-> ##[80:100] done;
    endproperty
    a_done_bound: assert property (p_done_bound)
        else $error("transfer did not finish in time");

    property p_dummy_bound;
        @(posedge sys_clk) disable iff (!rst_b)
        (req_valid && req_ready && needs_dummy(req, r.port_out))
            |-> ##[170:200] done;
    endproperty
    a_dummy_bound: assert property (p_dummy_bound)
        else $error("read with dummy did not finish in time");

    property p_dummy_rdata;
        @(posedge sys_clk) disable iff (!rst_b)
        r.dummy |=> $stable(rdata);
    endproperty
    a_dummy_rdata: assert property (p_dummy_rdata)
        else $error("dummy read changed read data");

    c_read: cover property (@(posedge sys_clk) disable iff (!rst_b)
        done && r.req.op == `NSX_OP_READ);
    c_write: cover property (@(posedge sys_clk) disable iff (!rst_b)
        done && r.req.op == `NSX_OP_WRITE);
    c_and: cover property (@(posedge sys_clk) disable iff (!rst_b)
        done && r.req.op == `NSX_OP_AND);
    c_dummy: cover property (@(posedge sys_clk) disable iff (!rst_b)
        r.state == nsx_pkg::NSX_CSH && r.dummy);
endmodule
`default_nettype wire

// [nsx_dev_model.sv]
// Behavioural expander on the far side of the host controller.
// Assumes one host drives strobe, select and the resolved nibble bus.
`timescale 1ns/10ps
`default_nettype none
module nsx_dev_model #(
    parameter logic [15:0] EXT = 16'h3c5a
) (
    input wire logic strobe,
    input wire logic chip_select_n,
    input wire logic [3:0] bus,
    output logic [3:0] dev_out,
    output logic dev_oe,
    output logic [15:0] pins
);
    logic [15:0] latch;
    logic [3:0] mode;
    logic [3:0] cmd;
    logic [3:0] sel;
    logic stale;
    logic strobe_int;
    assign strobe_int = strobe | chip_select_n;
    assign sel = {cmd[1:0], 2'b00};
    initial begin
        mode = 4'h0;
        cmd = 4'h0;
        stale = 1'b0;
        latch = 16'h0000;
    end
    always @(negedge strobe_int) begin
        cmd = bus;
        if (bus[3:2] == 2'h0) begin
            // Port leaving output mode still shows its latch this read
            stale = mode[bus[1:0]];
            mode[bus[1:0]] = 1'b0;
        end
    end
    always @(posedge strobe_int) begin
        stale = 1'b0;
        case (cmd[3:2])
            2'h1: latch[sel +: 4] = bus;
            2'h2: latch[sel +: 4] = latch[sel +: 4] | bus;
            2'h3: latch[sel +: 4] = latch[sel +: 4] & bus;
            default: ;
        endcase
        if (cmd[3:2] != 2'h0) begin
            mode[cmd[1:0]] = 1'b1;
        end
    end
    for (genvar g = 0; g < 4; g++) begin : g_pin
        assign pins[g*4 +: 4] = mode[g] ? latch[g*4 +: 4] : EXT[g*4 +: 4];
    end
    assign dev_oe = ~strobe_int & (cmd[3:2] == 2'h0);
    assign dev_out = stale ? latch[sel +: 4] : pins[sel +: 4];
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench: host controller against the expander model.
// Assumes nsx_pkg and nsx_host are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [15:0] EXT = 16'h3c5a;
    logic sys_clk, reset_n, req_valid, req_ready, done, strobe;
    logic chip_select_n, bus_oe, dev_oe;
    nsx_pkg::nsx_req_t req;
    logic [3:0] rdata, bus, bus_out, dev_out;
    logic [3:0] idle_pat = 4'h0;
    logic [15:0] pins;
    int err_count, cmp_count;
    nsx_host i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
        .done(done), .strobe(strobe), .chip_select_n(chip_select_n),
        .host_nibble_bus_in(bus), .host_nibble_bus_out(bus_out),
        .host_nibble_bus_oe(bus_oe));
    nsx_dev_model #(.EXT(EXT)) i_dev (.strobe(strobe),
        .chip_select_n(chip_select_n), .bus(bus), .dev_out(dev_out),
        .dev_oe(dev_oe), .pins(pins));
    // Undriven bus shows a pattern that changes every cycle
    assign bus = bus_oe ? bus_out : (dev_oe ? dev_out : idle_pat);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) idle_pat <= idle_pat + 4'h1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [1:0] op, input logic [1:0] port,
        input logic [3:0] data);
        int n;
        @(posedge sys_clk);
        req <= '{op: op, port: port, data: data};
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (done !== 1'b1 && n < 400);
        chk({15'h0, done}, 16'h0001);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_reset;
        chk({12'h0, req_ready, strobe, chip_select_n, bus_oe}, 16'h000e);
        chk(pins, EXT);
        $display("test reset done");
    endtask
    task automatic t_write_merge;
        xfer(2'h1, 2'h2, 4'h9);
        chk({12'h0, i_dev.cmd}, 16'h0006);
        chk(pins, 16'h395a);
        xfer(2'h2, 2'h2, 4'h4);
        chk(pins, 16'h3d5a);
        xfer(2'h3, 2'h2, 4'h6);
        chk(pins, 16'h345a);
        $display("test write merge done");
    endtask
    task automatic t_ports;
        xfer(2'h1, 2'h0, 4'h1);
        xfer(2'h1, 2'h1, 4'h2);
        xfer(2'h1, 2'h3, 4'h7);
        chk(pins, 16'h7421);
        $display("test ports done");
    endtask
    task automatic t_read;
        xfer(2'h0, 2'h2, 4'h0);
        chk({12'h0, rdata}, 16'h000c);
        xfer(2'h0, 2'h2, 4'h0);
        chk({12'h0, rdata}, 16'h000c);
        chk(pins, 16'h7c21);
        xfer(2'h0, 2'h0, 4'h0);
        chk({12'h0, rdata}, 16'h000a);
        chk(pins, 16'h7c2a);
        $display("test read done");
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
    initial begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        err_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_write_merge();
        t_ports();
        t_read();
        results();
    end
endmodule
`default_nettype wire
